// file: dma_sink_model.sv
// Host-side sink that takes the data-in stream of the engine.
`timescale 1ns/1ns
`default_nettype none
module dma_sink_model
    import elem_status_pkg::*;
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire elem_status_pkg::dma_word_t dma_out,
    input wire logic dma_valid,
    input wire logic stall_en,
    output logic dma_ready
);
    logic [31:0] mem [0:4095];
    int n_words;
    int last_at;
    logic [1:0] phase_q;
    // Stores each accepted word; stalls one cycle in three when asked.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            dma_ready <= 1'b0;
            n_words <= 0;
            last_at <= -1;
            phase_q <= 2'h0;
        end else begin
            phase_q <= (phase_q == 2'h2) ? 2'h0 : phase_q + 2'h1;
            dma_ready <= !(stall_en && phase_q == 2'h0);
            if (dma_valid && dma_ready) begin
                mem[n_words] <= dma_out.data;
                n_words <= n_words + 1;
                if (dma_out.last) last_at <= n_words;
            end
        end
    end
endmodule // dma_sink_model
`default_nettype wire

// file: elem_status.sv
// Element status report command engine with a Wishbone register slave.
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - Opcode 12h starts the query; results leave as a DMA data-in stream.
// - Filter sits in feature bits 15:14, report type in 11:8.
// - Filter 00b reports every element of the selected type.
// - Filter 01b reports only health 65h..CFh or FFh.
// - Count register holds page count, start register the first element.
// - Exactly the requested 512-byte pages are sent, padded with zero.
// - A short page count cuts the report without altering sent data.
// - Pages beyond the report content are sent as all zero.
// - An invalid first element aborts with illegal request, invalid field.
// - Status carries fault in bit 5, sense in bit 1, error in bit 0.
// - Sense data names one of the five listed additional sense codes.
// - Header count in bytes 0-3, reserved to 31, descriptors from 32.
// - Bytes after the last descriptor up to the end are zero.
// - Header count is elements passing filter with id at least start.
// - Descriptors leave in strictly ascending element id order.
// - Descriptor holds id at 4-7, type 14, health 15, capacity 16-23.
// - Element type is 01b for a storage element.
// - Health codes D0h..FEh are never stored or reported.
// - Capacity is blocks lost on depopulation; all-ones low bytes unknown.
module elem_status (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [elem_status_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic dev_fault,
    output elem_status_pkg::dma_word_t dma_out,
    output logic dma_valid,
    input wire logic dma_ready,
    output logic cmd_busy,
    output logic cmd_done
);
    import elem_status_pkg::*;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_SCAN = 4'b0010,
        ST_SEND = 4'b0100,
        ST_END = 4'b1000
    } state_t;

    // Sequencer state and the bus answer with its read data.
    state_t state_q, state_d;
    logic ack_q;
    logic [31:0] rdat_q;

    // Command fields as last written by the host.
    logic [15:0] feat_q;
    logic [15:0] count_q;
    logic [31:0] start_q;

    // Completion status, error byte and sense selector of the last command.
    logic [7:0] status_q;
    logic [7:0] error_q;
    sense_t sense_q;

    // Element table and the list of passing elements that the scan builds.
    logic [31:0] len_q;
    logic [7:0] hlth_q [NUM_ELEM];
    logic [63:0] cap_q [NUM_ELEM];
    logic [IDX_W-1:0] list_q [NUM_ELEM];
    logic [IDX_W:0] scan_q;

    // Data-in stream position and the registered output word.
    logic [22:0] word_q;
    logic [22:0] total_q;
    logic [WORD_W-1:0] out_data_q;
    logic out_last_q;
    logic valid_q;
    logic done_q;

    // Bus decode: a request is taken in the cycle before ack rises.
    wire logic req = wb_cyc_i & wb_stb_i & ~ack_q;
    wire logic wr = req & wb_we_i;
    wire logic in_elem = wb_adr_i[ELEM_BASE_BIT];
    wire logic [IDX_W-1:0] e_idx = wb_adr_i[6:4];
    wire logic [1:0] e_reg = wb_adr_i[3:2];
    wire logic [7:0] reg_adr = {wb_adr_i[7:2], 2'b00};
    wire logic wr_cmd = wr & ~in_elem & (reg_adr == REG_CMD) & wb_sel_i[0];
    wire logic idle = (state_q == ST_IDLE);

    // Byte-lane merge for writable words.
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // Byte-lane merges for the two 16-bit command fields.
    wire logic [31:0] feat_m = merge({16'h0000, feat_q}, wb_dat_i,
                                     wb_sel_i);
    wire logic [31:0] count_m = merge({16'h0000, count_q}, wb_dat_i,
                                      wb_sel_i);

    // Reserved health codes fold to not reported.
    function automatic logic [7:0] clamp_hlth(input logic [7:0] h);
        if (h >= HLTH_RSV_LO && h != HLTH_DEPOP) begin
            return HLTH_NONE;
        end
        return h;
    endfunction

    // Command field checks.
    wire logic [1:0] filt = feat_q[FILT_HI:FILT_LO];
    wire logic [3:0] rtype = feat_q[RTYPE_HI:RTYPE_LO];
    wire logic bad_field = (filt != FILT_ALL && filt != FILT_BAD) |
                           (rtype != RTYPE_ALL) |
                           (count_q == 16'h0000);
    wire logic bad_start = (start_q >= 32'(NUM_ELEM));
    wire logic go = wr_cmd & idle &
                    (wb_dat_i[7:0] == OPC_ELEM_STATUS);

    // Element selection for the scan index.
    wire logic [IDX_W-1:0] s_idx = scan_q[IDX_W-1:0];
    wire logic [7:0] s_h = hlth_q[s_idx];
    wire logic s_bad = (s_h >= HLTH_OUT_LO && s_h <= HLTH_OUT_HI) |
                       (s_h == HLTH_DEPOP);
    wire logic s_filt = (filt == FILT_ALL) | s_bad;
    wire logic s_pass = s_filt & (32'(s_idx) >= start_q);
    wire logic scan_end = (scan_q == (IDX_W+1)'(NUM_ELEM));

    // Word builder: header, then descriptors, then zero padding.
    wire logic [22:0] dword = word_q - HDR_WORDS;
    wire logic [19:0] desc_n = dword[22:DESC_SHIFT];
    wire logic [2:0] desc_w = dword[2:0];
    wire logic in_desc = (word_q >= HDR_WORDS) & (32'(desc_n) < len_q);
    wire logic [IDX_W-1:0] d_idx = list_q[desc_n[IDX_W-1:0]];
    logic [31:0] desc_word;
    always_comb begin
        desc_word = 32'h0000_0000;
        case (desc_w)
            DW_ID: desc_word = 32'(d_idx);
            DW_TYPE_HLTH: desc_word = {hlth_q[d_idx], ETYPE_STORAGE,
                                       16'h0000};
            DW_CAP_LO: desc_word = cap_q[d_idx][31:0];
            DW_CAP_HI: desc_word = cap_q[d_idx][63:32];
            default: desc_word = 32'h0000_0000;
        endcase
    end
    wire logic [31:0] next_word = (word_q == 23'h0) ? len_q :
                                  in_desc ? desc_word :
                                  32'h0000_0000;
    wire logic load = ~valid_q | dma_ready;
    wire logic more = (word_q != total_q);

    // Sequencer state selection.
    // A good command spends one cycle per table entry plus one in the scan, then
    // streams every requested word and passes through the end state once.
    // Aborted commands never leave idle, so the table scan is skipped.
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (go && !bad_field && !bad_start && !dev_fault) begin
                    state_d = ST_SCAN;
                end
            end
            ST_SCAN: begin
                if (scan_end) begin
                    state_d = ST_SEND;
                end
            end
            ST_SEND: begin
                if (!more && load) begin
                    state_d = ST_END;
                end
            end
            ST_END: state_d = ST_IDLE;
            default: state_d = ST_IDLE;
        endcase
    end

    // State register.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Wishbone acknowledge and read data.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ack_q <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else begin
            ack_q <= req;
            if (req && !wb_we_i) begin
                rdat_q <= 32'h0000_0000;
                if (in_elem) begin
                    case (e_reg)
                        EREG_HLTH: rdat_q <= 32'(hlth_q[e_idx]);
                        EREG_CAP_LO: rdat_q <= cap_q[e_idx][31:0];
                        EREG_CAP_HI: rdat_q <= cap_q[e_idx][63:32];
                        default: rdat_q <= 32'h0000_0000;
                    endcase
                end else begin
                    case (reg_adr)
                        REG_FEAT: rdat_q <= 32'(feat_q);
                        REG_COUNT: rdat_q <= 32'(count_q);
                        REG_START: rdat_q <= start_q;
                        REG_STAT: rdat_q <= {7'h00, ~idle, 5'h00, sense_q,
                                             error_q, status_q};
                        REG_LEN: rdat_q <= len_q;
                        default: rdat_q <= 32'h0000_0000;
                    endcase
                end
            end
        end
    end

    // Command field registers, writable only while idle.
    // Holding them during a command keeps the scan and the stream length
    // consistent with what was checked when the command started.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            feat_q <= 16'h0000;
            count_q <= 16'h0001;
            start_q <= 32'h0000_0000;
        end else if (wr && !in_elem && idle) begin
            if (reg_adr == REG_FEAT) begin
                feat_q <= feat_m[15:0];
            end
            if (reg_adr == REG_COUNT) begin
                count_q <= count_m[15:0];
            end
            if (reg_adr == REG_START) begin
                start_q <= merge(start_q, wb_dat_i, wb_sel_i);
            end
        end
    end

    // Element table, fed by firmware over the bus.
    // Writes are taken at any time; a change during a stream only shows
    // in descriptor words that have not yet left the engine.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            for (int i = 0; i < NUM_ELEM; i++) begin
                hlth_q[i] <= HLTH_NONE;
                cap_q[i] <= CAP_RESET;
            end
        end else if (wr && in_elem) begin
            case (e_reg)
                EREG_HLTH: begin
                    if (wb_sel_i[0]) begin
                        hlth_q[e_idx] <= clamp_hlth(wb_dat_i[7:0]);
                    end
                end
                EREG_CAP_LO: cap_q[e_idx][31:0] <=
                    merge(cap_q[e_idx][31:0], wb_dat_i, wb_sel_i);
                EREG_CAP_HI: cap_q[e_idx][63:32] <=
                    merge(cap_q[e_idx][63:32], wb_dat_i, wb_sel_i);
                default: cap_q[e_idx] <= cap_q[e_idx];
            endcase
        end
    end

    // Scan builds an ascending list of passing elements and their count.
    // Walking the table by index keeps the list sorted without a sorter,
    // since element identifiers are the table indices.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            scan_q <= '0;
            len_q <= 32'h0000_0000;
            for (int i = 0; i < NUM_ELEM; i++) begin
                list_q[i] <= '0;
            end
        end else if (go && idle) begin
            scan_q <= '0;
            len_q <= 32'h0000_0000;
        end else if (state_q == ST_SCAN && !scan_end) begin
            scan_q <= scan_q + 1'b1;
            if (s_pass) begin
                list_q[len_q[IDX_W-1:0]] <= s_idx;
                len_q <= len_q + 32'h1;
            end
        end
    end

    // Completion status and sense selector.
    // A fault outranks field errors, so the host sees the internal failure
    // first; the result stands until the next command register write while idle.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            status_q <= 8'h00;
            error_q <= 8'h00;
            sense_q <= SNS_NONE;
        end else if (wr_cmd && idle) begin
            status_q <= 8'h00;
            error_q <= 8'h00;
            sense_q <= SNS_NONE;
            if (wb_dat_i[7:0] != OPC_ELEM_STATUS) begin
                status_q[ST_ERR] <= 1'b1;
                error_q[ER_ABORT] <= 1'b1;
            end else if (dev_fault) begin
                status_q <= 8'h00 | (8'h1 << ST_FAULT) | (8'h1 << ST_SENSE) |
                            (8'h1 << ST_ERR);
                error_q[ER_ABORT] <= 1'b1;
                sense_q <= SNS_INT_FAIL;
            end else if (bad_field || bad_start) begin
                status_q[ST_SENSE] <= 1'b1;
                status_q[ST_ERR] <= 1'b1;
                error_q[ER_ABORT] <= 1'b1;
                sense_q <= SNS_INV_FIELD;
            end
        end
    end

    // Data-in stream: exactly count pages of words, then the end pulse.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            word_q <= 23'h0;
            total_q <= 23'h0;
            out_data_q <= 32'h0000_0000;
            out_last_q <= 1'b0;
            valid_q <= 1'b0;
        end else if (state_q == ST_SCAN) begin
            word_q <= 23'h0;
            total_q <= 23'(count_q) * 23'(WORDS_PER_PAGE);
            valid_q <= 1'b0;
        end else if (state_q == ST_SEND && load) begin
            valid_q <= more;
            // The end marker falls with valid, so it never outlives its word.
            out_last_q <= more & (word_q == total_q - 23'h1);
            if (more) begin
                out_data_q <= next_word;
                word_q <= word_q + 23'h1;
            end
        end else if (dma_ready) begin
            valid_q <= 1'b0;
        end
    end

    // One-cycle completion pulse for every command, aborted or not.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            done_q <= 1'b0;
        end else begin
            done_q <= (state_q == ST_END) |
                      (wr_cmd & idle & ~go) |
                      (go & (bad_field | bad_start | dev_fault));
        end
    end

    // Output wiring.
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;
    assign dma_out = {out_data_q, out_last_q};
    assign dma_valid = valid_q;
    assign cmd_busy = ~idle;
    assign cmd_done = done_q;
endmodule // elem_status

`default_nettype wire

// file: elem_status_chk.sv
// Port-level assertions for the element status engine.
`timescale 1ns/1ns
`default_nettype none
module elem_status_chk
    import elem_status_pkg::*;
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [elem_status_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic dev_fault,
    input wire elem_status_pkg::dma_word_t dma_out,
    input wire logic dma_valid,
    input wire logic dma_ready,
    input wire logic cmd_busy,
    input wire logic cmd_done
);
    // An opcode other than the query, written while the engine is idle.
    wire bad_opc = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && !cmd_busy
        && wb_adr_i == REG_CMD && wb_sel_i[0]
        && wb_dat_i[7:0] != OPC_ELEM_STATUS;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (srst);
    // Bus answer timing, stream framing and completion pulses.
    AST_ACK_NEXT: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not answered in one cycle");
    AST_ACK_DROP: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("bus answer held too long");
    AST_LAST_VALID: assert property (dma_out.last |-> dma_valid)
        else $error("last marker without a word");
    AST_HOLD: assert property (
        dma_valid && !dma_ready |=> dma_valid && $stable(dma_out))
        else $error("stalled word changed or vanished");
    AST_VALID_BUSY: assert property (dma_valid |-> cmd_busy)
        else $error("data offered outside a command");
    AST_DONE_ONE: assert property (cmd_done |=> !cmd_done)
        else $error("completion pulse too long");
    AST_DONE_END: assert property (
        dma_valid && dma_ready && dma_out.last |-> ##[1:4] cmd_done)
        else $error("no completion after final word");
    AST_ABORT_FAST: assert property (bad_opc |-> ##[1:3] cmd_done)
        else $error("unknown opcode not completed at once");
endmodule // elem_status_chk

bind elem_status elem_status_chk i_elem_status_chk (
    .clk_sys(clk_sys), .srst(srst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .dev_fault(dev_fault), .dma_out(dma_out),
    .dma_valid(dma_valid), .dma_ready(dma_ready), .cmd_busy(cmd_busy),
    .cmd_done(cmd_done)
);
`default_nettype wire

// file: elem_status_pkg.sv
// Constants, register map and carrier types of the element status engine.
package elem_status_pkg;
    localparam int NUM_ELEM = 8;
    localparam int IDX_W = 3;
    localparam int ADR_W = 8;
    // Command opcode and feature field positions.
    localparam logic [7:0] OPC_ELEM_STATUS = 8'h12;
    localparam int FILT_HI = 15;
    localparam int FILT_LO = 14;
    localparam int RTYPE_HI = 11;
    localparam int RTYPE_LO = 8;
    localparam logic [1:0] FILT_ALL = 2'h0;
    localparam logic [1:0] FILT_BAD = 2'h1;
    localparam logic [3:0] RTYPE_ALL = 4'h0;
    // Health codes.
    localparam logic [7:0] HLTH_NONE = 8'h00;
    localparam logic [7:0] HLTH_OUT_LO = 8'h65;
    localparam logic [7:0] HLTH_OUT_HI = 8'hcf;
    localparam logic [7:0] HLTH_RSV_LO = 8'hd0;
    localparam logic [7:0] HLTH_DEPOP = 8'hff;
    localparam logic [7:0] ETYPE_STORAGE = 8'h01;
    // Capacity reset value: unspecified amount.
    localparam logic [63:0] CAP_RESET = 64'h0000_ffff_ffff_ffff;
    // Data layout in 32-bit words.
    localparam int WORD_W = 32;
    localparam logic [7:0] WORDS_PER_PAGE = 8'h80;
    localparam logic [22:0] HDR_WORDS = 23'h000008;
    localparam int DESC_SHIFT = 3;
    localparam logic [2:0] DW_ID = 3'h1;
    localparam logic [2:0] DW_TYPE_HLTH = 3'h3;
    localparam logic [2:0] DW_CAP_LO = 3'h4;
    localparam logic [2:0] DW_CAP_HI = 3'h5;
    // Status and error bit positions.
    localparam int ST_FAULT = 5;
    localparam int ST_SENSE = 1;
    localparam int ST_ERR = 0;
    localparam int ER_ABORT = 2;
    // Register byte offsets.
    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_FEAT = 8'h04;
    localparam logic [7:0] REG_COUNT = 8'h08;
    localparam logic [7:0] REG_START = 8'h0c;
    localparam logic [7:0] REG_STAT = 8'h10;
    localparam logic [7:0] REG_LEN = 8'h14;
    localparam int ELEM_BASE_BIT = 7;
    localparam logic [1:0] EREG_HLTH = 2'h0;
    localparam logic [1:0] EREG_CAP_LO = 2'h1;
    localparam logic [1:0] EREG_CAP_HI = 2'h2;
    // Additional sense code selector.
    typedef enum logic [2:0] {
        SNS_NONE = 3'h0,
        SNS_INT_FAIL = 3'h1,
        SNS_STAT_WARN = 3'h2,
        SNS_PRED_FAIL = 3'h3,
        SNS_INV_FIELD = 3'h4
    } sense_t;
    localparam logic [3:0] SKEY_ILLEGAL = 4'h5;
    // One word of the data-in stream.
    typedef struct packed {
        logic [WORD_W-1:0] data;
        logic last;
    } dma_word_t;
endpackage

// file: test_physical_element_status_report.sv
// Self-checking bench for the element status engine.
`timescale 1ns/1ns
`default_nettype none
module test_physical_element_status_report;
    import elem_status_pkg::*;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic dev_fault = 1'b0;
    logic stall_en = 1'b0;
    dma_word_t dma_out;
    logic dma_valid;
    logic dma_ready;
    logic cmd_busy;
    logic cmd_done;
    int fail_count = 0;
    int tests_run = 0;
    int done_seen = 0;
    logic [7:0] hl [0:7];
    logic [63:0] cap [0:7];
    int ids [$];
    logic [31:0] rd;
    always #5 clk_sys = ~clk_sys;
    // Counts completion pulses so that no wait can miss one.
    always @(posedge clk_sys) begin
        if (cmd_done === 1'b1) begin
            done_seen <= done_seen + 1;
        end
    end
    elem_status i_elem_status (.clk_sys(clk_sys), .srst(srst),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .dev_fault(dev_fault),
        .dma_out(dma_out), .dma_valid(dma_valid), .dma_ready(dma_ready),
        .cmd_busy(cmd_busy), .cmd_done(cmd_done));
    dma_sink_model i_dma_sink_model (.clk_sys(clk_sys), .srst(srst),
        .dma_out(dma_out), .dma_valid(dma_valid), .stall_en(stall_en),
        .dma_ready(dma_ready));
    task automatic conclude();
        $display("tests_run %0d fail_count %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One classic bus cycle; holds the request until the answer is seen.
    task automatic wb(input logic we, input logic [7:0] adr,
            input logic [31:0] dat, output logic [31:0] q);
        int i;
        @(posedge clk_sys);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'hf;
        wb_dat_i <= dat;
        i = 0;
        do begin
            @(posedge clk_sys);
            i++;
        end while (wb_ack_o !== 1'b1 && i < 20);
        if (i >= 20) fail_count++;
        if (i >= 20) conclude();
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask
    // Word w of the expected data-in stream for the current list.
    function automatic logic [31:0] exp_word(input int w);
        int k;
        k = (w - 8) >> 3;
        if (w == 0) return ids.size();
        if (w < 8 || k >= ids.size()) return 32'h0;
        case ((w - 8) & 7)
            1: return ids[k];
            3: return {hl[ids[k]], ETYPE_STORAGE, 16'h0};
            4: return cap[ids[k]][31:0];
            5: return cap[ids[k]][63:32];
            default: return 32'h0;
        endcase
    endfunction
    // Sets up and runs one command, then checks stream, status and length.
    task automatic run(input logic [7:0] opc, input logic [15:0] feat,
            input logic [15:0] pc, input logic [31:0] st,
            input logic [10:0] stat);
        int base, nexp, w, d0;
        base = i_dma_sink_model.n_words;
        d0 = done_seen;
        wb(1'b1, REG_FEAT, {16'h0, feat}, rd);
        wb(1'b1, REG_COUNT, {16'h0, pc}, rd);
        wb(1'b1, REG_START, st, rd);
        wb(1'b1, REG_CMD, {24'h0, opc}, rd);
        check({31'h0, cmd_busy}, {31'h0, stat == 11'h0});
        for (w = 0; w < 4000 && done_seen == d0; w++) @(posedge clk_sys);
        if (done_seen == d0) fail_count++;
        if (done_seen == d0) conclude();
        ids = {};
        for (w = 0; w < 8; w++) begin
            if (w >= st && (feat[15:14] == FILT_ALL || hl[w] == HLTH_DEPOP
                    || (hl[w] >= HLTH_OUT_LO && hl[w] <= HLTH_OUT_HI)))
                ids.push_back(w);
        end
        nexp = (stat[7:0] == 8'h00) ? pc * 128 : 0;
        check(32'(i_dma_sink_model.n_words - base), 32'(nexp));
        for (w = 0; w < nexp; w++) begin
            check(i_dma_sink_model.mem[base + w], exp_word(w));
        end
        if (nexp > 0) begin
            w = i_dma_sink_model.last_at - base;
            check(32'(w), 32'(nexp - 1));
        end
        wb(1'b0, REG_STAT, 32'h0, rd);
        check({21'h0, rd[18:16], rd[7:0]}, {21'h0, stat});
        if (stat[0] && !stat[5]) check({31'h0, rd[10]}, 32'h1);
        wb(1'b0, REG_LEN, 32'h0, rd);
        if (nexp > 0) check(rd, 32'(ids.size()));
        $display("command %h feature %h pages %0d done", opc, feat, pc);
    endtask
    initial begin
        logic [7:0] ra [7] = '{REG_FEAT, REG_COUNT, REG_START, 8'h80, 8'h84,
            8'h88, 8'h40};
        logic [31:0] rv [7] = '{32'h0, 32'h1, 32'h0, 32'h0, CAP_RESET[31:0],
            CAP_RESET[63:32], 32'h0};
        logic [7:0] hw [8] = '{8'h10, 8'h65, 8'h64, 8'hcf, 8'hff, 8'hd0,
            8'h00, 8'hd1};
        logic [15:0] af [5] = '{16'h8000, 16'hc000, 16'h0100, 16'h0, 16'h0};
        int i;
        repeat (4) @(posedge clk_sys);
        srst <= 1'b0;
        for (i = 0; i < 7; i++) begin
            wb(1'b0, ra[i], 32'h0, rd);
            check(rd, rv[i]);
        end
        $display("reset values done");
        for (i = 0; i < 8; i++) begin
            hl[i] = (hw[i] >= HLTH_RSV_LO && hw[i] < HLTH_DEPOP) ? 8'h0
                : hw[i];
            cap[i] = {32'(i), 32'(i * 16 + 5)};
            wb(1'b1, 8'(8'h80 + 16 * i), {24'h0, hw[i]}, rd);
            wb(1'b1, 8'(8'h84 + 16 * i), cap[i][31:0], rd);
            wb(1'b1, 8'(8'h88 + 16 * i), cap[i][63:32], rd);
            wb(1'b0, 8'(8'h80 + 16 * i), 32'h0, rd);
            check(rd, {24'h0, hl[i]});
        end
        run(OPC_ELEM_STATUS, 16'h0, 16'h1, 32'h0, 11'h0);
        stall_en <= 1'b1;
        run(OPC_ELEM_STATUS, 16'h4000, 16'h2, 32'h2, 11'h0);
        run(OPC_ELEM_STATUS, 16'h0, 16'h1, 32'h7, 11'h0);
        for (i = 0; i < 5; i++) begin
            run(OPC_ELEM_STATUS, af[i], 16'(i != 3), 32'(i == 4 ? 8 : 0),
                11'h403);
        end
        dev_fault <= 1'b1;
        run(OPC_ELEM_STATUS, 16'h0, 16'h1, 32'h0, 11'h123);
        dev_fault <= 1'b0;
        run(8'h55, 16'h0, 16'h1, 32'h0, 11'h001);
        run(OPC_ELEM_STATUS, 16'h4000, 16'h1, 32'h0, 11'h0);
        conclude();
    end
endmodule // test_physical_element_status_report
`default_nettype wire
